// file: pfc_params.svh
// Purpose: constants for the parallel flash host controller
// Assumes: 100 MHz mclk, 10 ns period
// Notes:   times are in ns, cycle counts derive from them
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
`define PFC_CLK_NS        10
`define PFC_ACC_NS        90
`define PFC_CE_NS         90
`define PFC_PACC_NS       25
`define PFC_WP_NS         35
`define PFC_WPH_NS        20
`define PFC_RP_NS         500
`define PFC_CYC_UP(t)     (((t) + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_ACC_CYC       `PFC_CYC_UP(`PFC_ACC_NS)
`define PFC_CE_CYC        `PFC_CYC_UP(`PFC_CE_NS)
`define PFC_PACC_CYC      `PFC_CYC_UP(`PFC_PACC_NS)
`define PFC_WP_CYC        `PFC_CYC_UP(`PFC_WP_NS)
`define PFC_WPH_CYC       `PFC_CYC_UP(`PFC_WPH_NS)
`define PFC_RP_CYC        `PFC_CYC_UP(`PFC_RP_NS)
`define PFC_PAGE_LSB      2
`define PFC_BUF_WORDS     16
`endif

// file: pfc_pkg.sv
// Purpose: types for the parallel flash host controller
// Assumes: included params header
// Notes:   none
package pfc_pkg;
  typedef enum logic [2:0]
  {
    PFC_IDLE  = 3'b000,
    PFC_READ  = 3'b001,
    PFC_WLOW  = 3'b010,
    PFC_WHIGH = 3'b011,
    PFC_RST   = 3'b100
  } pfc_state_t;
  typedef struct packed
  {
    logic        write;
    logic [22:0] addr;
    logic [15:0] data;
  } pfc_req_t;
  typedef struct packed
  {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic word_sel;
  } pfc_ctl_t;
endpackage

// file: pfc_host.sv
// Purpose: host-side controller driving an asynchronous parallel NOR flash
// Assumes: pin inputs synchronous to mclk; device has no clock
// Notes:   one request at a time; commands are opaque address/data writes
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_host
#(
  parameter int AW      = 23,
  parameter int RP_CYC  = `PFC_RP_CYC
)
(
  input  wire logic             mclk,      // 100 MHz clock
  input  wire logic             rst_n,     // synchronous reset, low
  input  wire logic             req_valid, // request strobe
  input  wire pfc_pkg::pfc_req_t req,      // request fields
  input  wire logic             word_mode, // 1 word, 0 byte
  input  wire logic             boost_req, // accelerated program window
  input  wire logic             pulse_rst, // request device reset pulse
  output logic                  req_ready, // ready for a request
  output logic                  rd_valid,  // read data pulse
  output logic [15:0]           rd_data,   // read data
  output pfc_pkg::pfc_ctl_t     ctl,       // device control pins
  output logic [AW-1:0]         addr,      // device address
  output logic [15:0]           dq_o,      // data out
  output logic                  dq_oe,     // data output enable
  output logic                  top_o,     // data_line_top out (byte lsb)
  output logic                  top_oe,    // data_line_top enable
  output logic                  guard_boost_pin, // high = boost request
  input  wire logic [15:0]      dq_i       // data in
);
  import pfc_pkg::*;

  // ************************************************************
  // sequencer
  // ************************************************************
  pfc_state_t    state;
  logic [15:0]   cnt;
  logic          page_ok;
  logic [AW-1:0] page_addr;

  // requests carry byte addresses; the device pins take word addresses
  wire [AW-1:0] req_word = AW'(req.addr[$bits(req.addr)-1:1]);
  wire same_page = page_ok &&
    (req_word[AW-1:`PFC_PAGE_LSB] == page_addr[AW-1:`PFC_PAGE_LSB]);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state     <= PFC_RST;
      cnt       <= 16'(RP_CYC);
      ctl       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0, word_sel: 1'b1};
      addr      <= '0;
      dq_o      <= '0;
      dq_oe     <= 1'b0;
      top_o     <= 1'b0;
      top_oe    <= 1'b0;
      req_ready <= 1'b0;
      rd_valid  <= 1'b0;
      rd_data   <= '0;
      page_ok   <= 1'b0;
      page_addr <= '0;
    end
    else
    begin
      rd_valid     <= 1'b0;
      ctl.word_sel <= word_mode;
      unique case (state)
        PFC_IDLE:
        begin
          if (pulse_rst)
          begin
            // abort: device floats and returns to read array
            ctl       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0,
                           word_sel: word_mode};
            dq_oe     <= 1'b0;
            top_oe    <= 1'b0;
            page_ok   <= 1'b0;
            req_ready <= 1'b0;
            cnt       <= 16'(RP_CYC);
            state     <= PFC_RST;
          end
          else if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            addr      <= req_word;
            top_o     <= req.addr[0];
            top_oe    <= !word_mode;
            if (req.write)
            begin
              ctl.ce_n <= 1'b0;
              ctl.we_n <= 1'b0;
              ctl.oe_n <= 1'b1;
              dq_o     <= req.data;
              dq_oe    <= 1'b1;
              page_ok  <= 1'b0;
              cnt      <= 16'(`PFC_WP_CYC);
              state    <= PFC_WLOW;
            end
            else
            begin
              ctl.ce_n <= 1'b0;
              ctl.oe_n <= 1'b0;
              ctl.we_n <= 1'b1;
              dq_oe    <= 1'b0;
              // within an open page only the short time is needed
              cnt      <= same_page ? 16'(`PFC_PACC_CYC)
                                    : 16'(`PFC_CE_CYC);
              page_addr <= req_word;
              page_ok   <= 1'b1;
              state     <= PFC_READ;
            end
          end
          else if (!req_valid)
          begin
            // idle select dropped: next read pays full time again
            ctl.ce_n <= 1'b1;
            ctl.oe_n <= 1'b1;
            page_ok  <= 1'b0;
            req_ready <= 1'b1;
          end
          else
            req_ready <= 1'b1;
        end
        PFC_READ:
        begin
          if (cnt <= 16'd1)
          begin
            rd_data   <= word_mode ? dq_i : {8'h00, dq_i[7:0]};
            rd_valid  <= 1'b1;
            req_ready <= 1'b1;
            state     <= PFC_IDLE; // select held for page follow-on
          end
          else
            cnt <= cnt - 16'd1;
        end
        PFC_WLOW:
        begin
          if (cnt <= 16'd1)
          begin
            ctl.we_n <= 1'b1;
            cnt      <= 16'(`PFC_WPH_CYC);
            state    <= PFC_WHIGH;
          end
          else
            cnt <= cnt - 16'd1;
        end
        PFC_WHIGH:
        begin
          if (cnt <= 16'd1)
          begin
            ctl.ce_n  <= 1'b1;
            dq_oe     <= 1'b0;
            req_ready <= 1'b1;
            state     <= PFC_IDLE;
          end
          else
            cnt <= cnt - 16'd1;
        end
        PFC_RST:
        begin
          if (cnt <= 16'd1)
          begin
            ctl.reset_n <= 1'b1;
            // restarts are only taken once the device accepts commands again
            req_ready   <= 1'b1;
            state       <= PFC_IDLE;
          end
          else
            cnt <= cnt - 16'd1;
        end
        default:
          state <= PFC_IDLE;
      endcase
    end
  end

  // ************************************************************
  // boost pin: registered, so it drops only one cycle after a read or reset begins
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      guard_boost_pin <= 1'b0;
    else
      guard_boost_pin <= boost_req && ctl.reset_n && state != PFC_READ;
  end

  // ************************************************************
  // checks
  // ************************************************************
  rd_gate_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PFC_READ) |-> (!ctl.ce_n && !ctl.oe_n && ctl.we_n))
    else $error("read without select and gate low");
  wr_gate_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ctl.we_n) |-> (!ctl.ce_n && ctl.oe_n && dq_oe))
    else $error("write strobe with gate low");
  no_fight_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!ctl.oe_n) |-> !dq_oe)
    else $error("bus driven while gate low");
  rst_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(ctl.reset_n) |-> !ctl.reset_n [*8])
    else $error("reset pulse too short");
  boost_safe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PFC_READ) |=> !guard_boost_pin)
    else $error("boost during read");
  byte_top_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PFC_READ && !ctl.word_sel) |-> top_oe)
    else $error("byte lsb not driven");
  rd_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == PFC_IDLE && req_valid && req_ready && !req.write && !pulse_rst)
      |-> ##[1:20] rd_valid)
    else $error("read did not finish");
  ready_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_valid |-> req_ready)
    else $error("ready missing after read");

  // ************************************************************
  // reset pulse length watch
  // ************************************************************
  logic [15:0] rst_len;

  always_ff @(posedge mclk)
  begin
    if (!rst_n || ctl.reset_n)
      rst_len <= '0;
    else if (rst_len != 16'hFFFF)
      rst_len <= rst_len + 16'h1;
  end

  rst_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ctl.reset_n) |-> (rst_len >= 16'(RP_CYC - 1)))
    else $error("reset pulse shorter than minimum");
endmodule

// file: pfc_flash_model.sv
// Purpose: behavioural flash device on the pin side of the host
// Assumes: mclk is only a timebase for sampling the pins
// Notes:   released data lines toggle, so stale values never match
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_flash_model
#(
  parameter int AW = 23
)
(
  input  wire logic              mclk,  // timebase
  input  wire pfc_pkg::pfc_ctl_t ctl,   // control pins
  input  wire logic [AW-1:0]     addr,  // word address pins
  input  wire logic [15:0]       dq_o,  // host data
  input  wire logic              dq_oe, // host drives data
  input  wire logic              top_o, // byte lsb
  input  wire logic              guard, // boost pin
  output logic [15:0]            dq_i   // device data
);
  import pfc_pkg::*;
  // ****************************************
  // access timing and array
  // ****************************************
  localparam real ACC  = `PFC_ACC_NS - 5;
  localparam real PACC = `PFC_PACC_NS - 5;
  realtime       t_chg = 0;
  logic [AW:0]   last_a = '0;
  logic          page_open = 1'b0;
  logic [15:0]   word;
  logic [AW-1:0] wr_addr;
  logic [15:0]   wr_data;
  int            wr_cnt = 0;
  int            bad_bus = 0;
  initial dq_i = 16'h0000;
  // a new page, a deselect or a reset pulse costs a full access again
  always @(addr, top_o, ctl.ce_n, ctl.reset_n)
  begin
    if (ctl.ce_n || !ctl.reset_n || addr[AW-1:2] !== last_a[AW:3])
      page_open = 1'b0;
    last_a = {addr, top_o};
    t_chg = $realtime;
  end
  always @(negedge mclk)
  begin
    word = addr[15:0] ^ 16'hA5C3;
    if (ctl.reset_n && !ctl.ce_n && !ctl.oe_n && ctl.we_n &&
        $realtime - t_chg >= (page_open ? PACC : ACC))
    begin
      page_open = 1'b1;
      dq_i <= ctl.word_sel ? word : {~dq_i[15:8], top_o ? word[15:8] : word[7:0]};
    end
    else
      dq_i <= ~dq_i;
    if (!ctl.oe_n && (!ctl.we_n || guard))
      bad_bus++;
    if (!ctl.reset_n)
      wr_cnt = 0;
  end
  // commands stay opaque pairs: erase, buffer and autoselect are not decoded
  // a captured command runs on after deselect; nothing waits on ce_n
  always @(posedge ctl.we_n)
    if (!ctl.ce_n && ctl.oe_n && dq_oe && ctl.reset_n)
    begin
      wr_addr = addr;
      wr_data = dq_o;
      wr_cnt++;
    end
endmodule

// file: pfc_host_tb.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: pfc_flash_model on the pin side
// Notes:   device reset pulse shortened to RP cycles
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_host_tb;
  import pfc_pkg::*;
  // ****************************************
  // harness
  // ****************************************
  localparam int RP = 10;
  logic mclk, rst_n, req_valid, word_mode, boost_req, pulse_rst;
  logic req_ready, rd_valid, dq_oe, top_o, top_oe, guard;
  logic [15:0] rd_data, dq_o, dq_i;
  logic [22:0] addr;
  pfc_req_t    req;
  pfc_ctl_t    ctl;
  int          miscompares = 0;
  int          checks_done = 0;
  int          w;
  pfc_host #(.AW(23), .RP_CYC(RP)) u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req(req), .word_mode(word_mode), .boost_req(boost_req), .pulse_rst(pulse_rst),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .ctl(ctl), .addr(addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .top_o(top_o), .top_oe(top_oe), .guard_boost_pin(guard),
    .dq_i(dq_i));
  pfc_flash_model #(.AW(23)) u_mem (.mclk(mclk), .ctl(ctl), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .top_o(top_o), .guard(guard), .dq_i(dq_i));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // levels are read before the edge's own updates land
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 300)
    begin
      miscompares++;
      finish_test();
    end
  endtask
  function automatic logic [15:0] expect_rd(input logic [22:0] a, input logic wm);
    logic [15:0] v;
    v = a[16:1] ^ 16'hA5C3;
    return wm ? v : {8'h00, a[0] ? v[15:8] : v[7:0]};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  // back-to-back reads that cross a page in mid-burst
  task automatic burst(input logic [22:0] a0, input int n, input logic wm);
    logic [22:0] a;
    logic [19:0] pg;
    int          exp_w;
    word_mode <= wm;
    repeat (2) @(posedge mclk);
    req <= '{1'b0, a0, 16'h0000};
    req_valid <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < n; k++)
    begin
      a = a0 + k * (wm ? 2 : 1);
      wait_hi(req_ready, w);
      if (k == n - 1)
        req_valid <= 1'b0;
      else
        req <= '{1'b0, a + (wm ? 23'h2 : 23'h1), 16'h0000};
      repeat (2) @(posedge mclk);
      wait_hi(rd_valid, w);
      check(rd_data, expect_rd(a, wm));
      check(top_oe, !wm);
      // w counts from the second edge after the take
      exp_w = (k == 0 || a[22:3] != pg) ? `PFC_CE_CYC - 1 : `PFC_PACC_CYC - 1;
      check(w, exp_w);
      pg = a[22:3];
    end
    repeat (3) @(posedge mclk);
    check({ctl.ce_n, dq_oe}, 2'b10);
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    int c;
    c = u_mem.wr_cnt;
    req <= '{1'b1, a, d};
    req_valid <= 1'b1;
    @(posedge mclk);
    wait_hi(req_ready, w);
    req_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    wait_hi(req_ready, w);
    check(w, `PFC_WP_CYC + `PFC_WPH_CYC - 1);
    check(u_mem.wr_addr, a[22:1]);
    check(u_mem.wr_data, d);
    check(u_mem.wr_cnt, c + 1);
  endtask
  task automatic pulse_check(input logic go);
    pulse_rst <= go;
    @(posedge mclk);
    pulse_rst <= 1'b0;
    @(posedge mclk);
    w = 0;
    while (ctl.reset_n !== 1'b1 && w < 300)
    begin
      @(posedge mclk);
      w++;
    end
    if (w >= 300)
    begin
      miscompares++;
      finish_test();
    end
    check(w >= RP - 2 && w <= RP + 2, 1'b1);
    check(u_mem.wr_cnt, 0);
  endtask
  initial
  begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    word_mode = 1'b1;
    boost_req = 1'b0;
    pulse_rst = 1'b0;
    repeat (12) @(posedge mclk);
    check({ctl.ce_n, ctl.oe_n, ctl.we_n, ctl.reset_n, req_ready}, 5'h1C);
    rst_n <= 1'b1;
    pulse_check(1'b0);
    burst(23'h000104, 4, 1'b1);
    burst(23'h000106, 4, 1'b0);
    boost_req <= 1'b1;
    repeat (3) @(posedge mclk);
    check(guard, 1'b1);
    wr(23'h000AAA, 16'h0A0A);
    wr(23'h0000F0, 16'h1234);
    boost_req <= 1'b0;
    repeat (3) @(posedge mclk);
    check(guard, 1'b0);
    for (int i = 0; i < 16; i++)
      wr(23'(23'h000200 + 2 * i), 16'(16'hC000 + i));
    pulse_check(1'b1);
    burst(23'h0000FE, 2, 1'b1);
    check(u_mem.bad_bus, 0);
    finish_test();
  end
endmodule
